//--- lcd_pkg.sv
// shared constants of the lcd segment/common driver
package lcd_pkg;

  // register word indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE      = 16'hFFB0;
  localparam logic [15:0] IDX_TIMER     = 16'hFFB1;
  localparam logic [15:0] IDX_SEG_CTL   = 16'hFFB2;
  localparam logic [15:0] IDX_PORT_OUT  = 16'hFFB3;
  localparam logic [15:0] IDX_PORT_DIR  = 16'hFFB4;
  localparam logic [15:0] IDX_PORT_IN   = 16'hFFB5;
  localparam logic [15:0] IDX_MODE_SET  = 16'hFFB6;
  localparam logic [15:0] IDX_MODE_CLR  = 16'hFFB7;
  localparam logic [15:0] IDX_DDM_FIRST = 16'hFA58;
  localparam logic [15:0] IDX_DDM_LAST  = 16'hFA7F;

  // display mode register fields
  localparam int          MODE_ON_BIT   = 7;
  localparam int          MODE_CLK_LSB  = 4;
  localparam int          MODE_SEL_LSB  = 0;
  localparam logic [7:0]  MODE_WMASK    = 8'hF7;
  localparam logic [7:0]  MODE_RESET    = 8'h00;

  // clock timer control fields
  localparam int          TMR_SRC_BIT   = 0;
  localparam int          TMR_SUPPLY_BIT = 1;
  localparam logic [1:0]  TMR_RESET     = 2'h0;

  // display mode codes
  localparam logic [2:0]  MODE_4DIV_B3  = 3'h0;
  localparam logic [2:0]  MODE_3DIV_B3  = 3'h1;
  localparam logic [2:0]  MODE_2DIV_B2  = 3'h2;
  localparam logic [2:0]  MODE_3DIV_B2  = 3'h3;
  localparam logic [2:0]  MODE_STATIC   = 3'h4;

  // panel clock prescaler masks for 2^9, 2^8, 2^7, 2^6
  localparam logic [8:0]  DIV_MASK_512  = 9'h1FF;
  localparam logic [8:0]  DIV_MASK_256  = 9'h0FF;
  localparam logic [8:0]  DIV_MASK_128  = 9'h07F;
  localparam logic [8:0]  DIV_MASK_64   = 9'h03F;

  // main clock to clock timer ratio, 2^7
  localparam logic [6:0]  MAIN_DIV_LAST = 7'h7F;

  localparam int          NUM_SEG       = 40;
  localparam int          NUM_SHARED    = 16;
  localparam int          FIRST_SHARED  = 24;
  localparam int          NUM_COM       = 4;

endpackage

//--- lcd_disp_mem.sv
// display data memory: 40 entries of 4 bits in flip-flops
`timescale 1ns/100ps
module lcd_disp_mem
  import lcd_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              wr_en,
  input  wire logic [5:0]        wr_idx,
  input  wire logic [3:0]        wr_data,
  input  wire logic [5:0]        rd_idx,
  input  wire logic [1:0]        plane,
  output logic      [3:0]        rd_data,
  output logic      [NUM_SEG-1:0] column
);

  logic [3:0] mem [NUM_SEG];

  // one entry per segment; upper nibble has no storage and reads zero
  for (genvar g = 0; g < NUM_SEG; g++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[g] <= 4'h0;
      end else if (wr_en && (wr_idx == 6'(g))) begin
        mem[g] <= wr_data;
      end
    end
    // all segments read the bit plane of the active common at once
    assign column[g] = mem[g][plane];
  end

  assign rd_data = (rd_idx < 6'(NUM_SEG)) ? mem[rd_idx] : 4'h0;

endmodule // lcd_disp_mem

//--- lcd_clk_div.sv
// clock timer source selection and panel clock prescaler
`timescale 1ns/100ps
module lcd_clk_div
  import lcd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sub_clk,
  input  wire logic       src_sub,
  input  wire logic       supply,
  input  wire logic [2:0] rate,
  output logic            slot_tick
);

  logic [6:0] main_cnt;
  logic       sub_s1;
  logic       sub_s2;
  logic       sub_s3;
  logic       fw_tick;
  logic [8:0] pre_cnt;
  logic [8:0] mask;

  // main clock divided by 2^7 into the clock timer tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_cnt <= 7'h00;
    end else begin
      main_cnt <= main_cnt + 7'h01;
    end
  end

  // subsystem clock pin: two-flop synchroniser, edge found after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else begin
      sub_s1 <= sub_clk;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  // clock timer tick from a subsystem clock edge sampled on pclk, or from the main divider
  assign fw_tick = src_sub ? (sub_s2 & ~sub_s3) : (main_cnt == MAIN_DIV_LAST);

  // only the two low bits carry a defined rate
  always_comb begin
    unique case (rate[1:0])
      2'h0: mask = DIV_MASK_512;
      2'h1: mask = DIV_MASK_256;
      2'h2: mask = DIV_MASK_128;
      2'h3: mask = DIV_MASK_64;
    endcase
  end

  // prescaler held cleared while the supply bit is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt   <= 9'h000;
      slot_tick <= 1'b0;
    end else if (!supply) begin
      pre_cnt   <= 9'h000;
      slot_tick <= 1'b0;
    end else begin
      if (fw_tick) begin
        pre_cnt <= pre_cnt + 9'h001;
      end
      slot_tick <= fw_tick && ((pre_cnt & mask) == mask);
    end
  end

  // a switch to the subsystem source may tick at once; only main ticks count
  sequence quiet8;
    (src_sub || !fw_tick) [*8];
  endsequence

  chk_main_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (!src_sub && fw_tick) |=> quiet8)
    else $error("main clock timer tick repeats too soon");

  chk_supply_gates_clk: assert property (@(posedge pclk) disable iff (!presetn)
    (!supply ##1 !supply) |-> !slot_tick)
    else $error("panel clock ran without supply bit");

endmodule // lcd_clk_div

//--- lcd_driver.sv
// lcd segment/common driver: apb registers, slot timing, line codes
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps

// Function
// - three-bit mode field picks 4/3/2/3 divisions or static; other codes prohibited
// - three-bit clock field divides clock timer tick by 2^9, 2^8, 2^7 or 2^6
// - clock timer tick is main clock over 2^7 or the subsystem clock
// - panel clock runs only while the supply bit is one
// - display off forces all segment lines to non-selection
// - reset clears the whole display mode register to zero
// - display mode fields writable alone, by bit set/clear or whole word
// - display memory is fetched automatically for continuous refresh
// - forty segment lines and four commons; sixteen segments shared with port
// - shared segment lines switch to port function in adjacent pairs
// - commons used are 0-1, 0-2 or 0-3 by division count; static uses all four
// - in slot of common n, bit n of each entry selects segment
// - static drives all commons alike; unused commons stay open
// - segment-mode pin reads zero as port; port latch has no effect
module lcd_driver
  import lcd_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [17:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  sub_clk,
  input  wire logic [NUM_SHARED-1:0] port_pin_in,
  output logic      [NUM_SHARED-1:0] port_pin_out,
  output logic      [NUM_SHARED-1:0] port_pin_oe,
  output logic      [NUM_SEG-1:0]    seg_sel,
  output logic      [NUM_COM-1:0]    com_sel,
  output logic      [NUM_COM-1:0]    com_drive,
  output logic                       polarity
);

  logic [7:0]            lcd_display_mode;
  logic [1:0]            clock_timer_mode_reg;
  logic [7:0]            segment_pin_control;
  logic [NUM_SHARED-1:0] port_latch;
  logic [NUM_SHARED-1:0] port_dir;
  logic [NUM_SHARED-1:0] port_s1;
  logic [NUM_SHARED-1:0] port_s2;
  logic [NUM_SHARED-1:0] port_rd;
  logic [NUM_SHARED-1:0] seg_mode;
  logic [15:0]           idx;
  logic                  access;
  logic                  done;
  logic                  wr;
  logic                  mem_hit;
  logic [5:0]            mem_idx;
  logic [3:0]            mem_rd;
  logic [NUM_SEG-1:0]    column;
  logic [31:0]           rd_val;
  logic                  mapped;
  logic                  slot_tick;
  logic [1:0]            com_idx;
  logic [1:0]            last_com;
  logic [NUM_COM-1:0]    next_com_drive;
  logic                  is_static;
  logic                  legal;
  logic                  disp_live;
  logic [NUM_SEG-1:0]    next_seg;
  logic                  display_enable_bit;
  logic [2:0]            mode_sel;
  logic [2:0]            clk_sel;

  assign display_enable_bit = lcd_display_mode[MODE_ON_BIT];
  assign mode_sel           = lcd_display_mode[MODE_SEL_LSB +: 3];
  assign clk_sel            = lcd_display_mode[MODE_CLK_LSB +: 3];

  // apb decode; writes land only on the edge that completes the access
  assign idx     = paddr[17:2];
  assign access  = psel & penable;
  assign done    = access & pready;
  assign wr      = done & pwrite;
  assign mem_hit = (idx >= IDX_DDM_FIRST) && (idx <= IDX_DDM_LAST);
  assign mem_idx = 6'(idx - IDX_DDM_FIRST);

  // one wait state so read data and errors come from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // read mux; unmapped addresses read zero with an error
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    if (mem_hit) begin
      rd_val = {28'h0000000, mem_rd};
    end else begin
      unique case (idx)
        IDX_MODE:     rd_val = {24'h000000, lcd_display_mode};
        IDX_TIMER:    rd_val = {30'h00000000, clock_timer_mode_reg};
        IDX_SEG_CTL:  rd_val = {24'h000000, segment_pin_control};
        IDX_PORT_OUT: rd_val = {16'h0000, port_latch};
        IDX_PORT_DIR: rd_val = {16'h0000, port_dir};
        IDX_PORT_IN:  rd_val = {16'h0000, port_rd};
        IDX_MODE_SET: rd_val = {24'h000000, lcd_display_mode};
        IDX_MODE_CLR: rd_val = {24'h000000, lcd_display_mode};
        default:      mapped = 1'b0;
      endcase
    end
  end

  // mode register: whole write, or set/clear aliases for single fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcd_display_mode <= MODE_RESET;
    end else if (wr && idx == IDX_MODE) begin
      lcd_display_mode <= pwdata[7:0] & MODE_WMASK;
    end else if (wr && idx == IDX_MODE_SET) begin
      lcd_display_mode <= lcd_display_mode | (pwdata[7:0] & MODE_WMASK);
    end else if (wr && idx == IDX_MODE_CLR) begin
      lcd_display_mode <= lcd_display_mode & ~pwdata[7:0];
    end
  end

  // clock timer control, pin function and port registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_timer_mode_reg <= TMR_RESET;
      segment_pin_control  <= 8'h00;
      port_latch           <= 16'h0000;
      port_dir             <= 16'h0000;
    end else if (wr) begin
      if (idx == IDX_TIMER) begin
        clock_timer_mode_reg <= pwdata[1:0];
      end
      if (idx == IDX_SEG_CTL) begin
        segment_pin_control <= pwdata[7:0];
      end
      if (idx == IDX_PORT_OUT) begin
        port_latch <= pwdata[15:0];
      end
      if (idx == IDX_PORT_DIR) begin
        port_dir <= pwdata[15:0];
      end
    end
  end

  lcd_disp_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr && mem_hit),
    .wr_idx  (mem_idx),
    .wr_data (pwdata[3:0]),
    .rd_idx  (mem_idx),
    .plane   (com_idx),
    .rd_data (mem_rd),
    .column  (column)
  );

  lcd_clk_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .sub_clk   (sub_clk),
    .src_sub   (clock_timer_mode_reg[TMR_SRC_BIT]),
    .supply    (clock_timer_mode_reg[TMR_SUPPLY_BIT]),
    .rate      (clk_sel),
    .slot_tick (slot_tick)
  );

  // mode decode; prohibited codes blank the segments
  always_comb begin
    legal          = 1'b1;
    is_static      = 1'b0;
    last_com       = 2'h3;
    next_com_drive = 4'hF;
    unique case (mode_sel)
      MODE_4DIV_B3: begin
        last_com       = 2'h3;
        next_com_drive = 4'hF;
      end
      MODE_3DIV_B3, MODE_3DIV_B2: begin
        last_com       = 2'h2;
        next_com_drive = 4'h7;
      end
      MODE_2DIV_B2: begin
        last_com       = 2'h1;
        next_com_drive = 4'h3;
      end
      MODE_STATIC: begin
        last_com       = 2'h0;
        is_static      = 1'b1;
        next_com_drive = 4'hF;
      end
      default: begin
        legal          = 1'b0;
        last_com       = 2'h0;
        next_com_drive = 4'h0;
      end
    endcase
  end

  // slot walk over the commons; polarity flips each frame for ac drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_idx  <= 2'h0;
    end else if (slot_tick) begin
      if (com_idx >= last_com) begin
        com_idx <= 2'h0;
      end else begin
        com_idx <= com_idx + 2'h1;
      end
    end
  end

  // segment codes straight from memory each slot, no cpu refresh needed
  assign disp_live = display_enable_bit & legal;
  assign next_seg  = disp_live ? column : '0;

  // registered line codes; analog levels are built outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_sel   <= '0;
      com_sel   <= 4'h0;
      com_drive <= 4'h0;
      polarity  <= 1'b0;
    end else begin
      seg_sel   <= next_seg;
      com_drive <= next_com_drive;
      com_sel   <= is_static ? 4'hF : (next_com_drive & (4'h1 << com_idx));
      if (slot_tick && com_idx >= last_com) begin
        polarity <= ~polarity;
      end
    end
  end

  // port pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_s1 <= 16'h0000;
      port_s2 <= 16'h0000;
    end else begin
      port_s1 <= port_pin_in;
      port_s2 <= port_s1;
    end
  end

  // shared pins; one control bit per adjacent pair
  for (genvar p = 0; p < NUM_SHARED; p++) begin : g_pin
    assign seg_mode[p] = segment_pin_control[p / 2];
    assign port_rd[p]  = port_s2[p] & ~seg_mode[p];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        port_pin_out[p] <= 1'b0;
        port_pin_oe[p]  <= 1'b0;
      end else begin
        // latch is ignored while the pin shows a segment
        port_pin_out[p] <= seg_mode[p] ? next_seg[FIRST_SHARED + p] : port_latch[p];
        port_pin_oe[p]  <= seg_mode[p] | port_dir[p];
      end
    end
  end

  sequence mode_set_write;
    wr && idx == IDX_MODE_SET;
  endsequence

  sequence frame_end;
    slot_tick && com_idx >= last_com;
  endsequence

  chk_off_blanks_segs: assert property (@(posedge pclk) disable iff (!presetn)
    !display_enable_bit |=> (seg_sel == '0))
    else $error("segments active while display off");

  chk_reset_mode_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (lcd_display_mode == 8'h00))
    else $error("mode register not cleared by reset");

  chk_mode_set_only: assert property (@(posedge pclk) disable iff (!presetn)
    mode_set_write |=> (lcd_display_mode ==
      ($past(lcd_display_mode) | ($past(pwdata[7:0]) & MODE_WMASK))))
    else $error("set alias disturbed other mode bits");

  chk_slot_advance: assert property (@(posedge pclk) disable iff (!presetn)
    (slot_tick && com_idx < last_com) |=> (com_idx == $past(com_idx) + 2'h1))
    else $error("common slot did not advance");

  chk_seg_follows_mem: assert property (@(posedge pclk) disable iff (!presetn)
    disp_live |=> (seg_sel == $past(column)))
    else $error("segment codes differ from memory plane");

  chk_static_commons: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_sel == MODE_STATIC) |=> (com_sel == 4'hF && com_drive == 4'hF))
    else $error("static commons not identical");

  chk_two_div_open: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_sel == MODE_2DIV_B2) |=> (com_drive == 4'h3 && com_sel[3:2] == 2'h0))
    else $error("unused commons driven in two-division mode");

  chk_seg_pin_reads_0: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready && !pwrite && idx == IDX_PORT_IN && segment_pin_control[0])
      |=> (prdata[1:0] == 2'h0))
    else $error("segment pin read as nonzero port");

  chk_pair_switch: assert property (@(posedge pclk) disable iff (!presetn)
    segment_pin_control[1] |=> (port_pin_oe[3:2] == 2'h3))
    else $error("pin pair not switched together");

  chk_illegal_blank: assert property (@(posedge pclk) disable iff (!presetn)
    !legal |=> (seg_sel == '0 && com_drive == 4'h0))
    else $error("prohibited mode drove the panel");

  // register and frame checks beyond the basic ones above
  chk_mode_whole_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == IDX_MODE) |=> (lcd_display_mode == ($past(pwdata[7:0]) & MODE_WMASK)))
    else $error("whole mode write not taken");

  chk_mode_clear_only: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == IDX_MODE_CLR) |=> (lcd_display_mode ==
      ($past(lcd_display_mode) & ~$past(pwdata[7:0]))))
    else $error("clear alias disturbed other mode bits");

  chk_frame_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end |=> (polarity != $past(polarity)))
    else $error("phase did not flip at frame end");

  chk_slot_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end |=> (com_idx == 2'h0))
    else $error("common slot did not wrap to the first common");

  chk_latch_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    seg_mode[0] |=> (port_pin_out[0] == $past(next_seg[FIRST_SHARED])))
    else $error("port latch reached a segment pin");

  chk_three_div_open: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_sel == MODE_3DIV_B3 || mode_sel == MODE_3DIV_B2)
      |=> (com_drive == 4'h7 && !com_sel[3]))
    else $error("unused common driven in three-division mode");

endmodule // lcd_driver

//--- lcd_panel_model.sv
// lcd panel stand-in: times common slots and resolves the shared pins
`timescale 1ns/100ps
module lcd_panel_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  com_sel,
  input  wire logic        polarity,
  input  wire logic [15:0] port_pin_out,
  input  wire logic [15:0] port_pin_oe,
  output logic      [15:0] port_pin_in,
  output int               slot_count,
  output int               last_period
);
  logic [3:0]  prev_com;
  logic [15:0] float_lvl;
  logic        prev_pol;
  logic        edge_seen;
  int          run;

  // static mode keeps every common selected, so its slots show only as phase flips
  assign edge_seen = (com_sel != prev_com) || (com_sel == 4'hF && polarity != prev_pol);

  // a slot boundary is a change of the common selection or a static phase flip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_com    <= 4'h0;
      prev_pol    <= 1'b0;
      slot_count  <= 0;
      last_period <= 0;
      run         <= 0;
    end else begin
      prev_com <= com_sel;
      prev_pol <= polarity;
      run      <= edge_seen ? 1 : run + 1;
      if (edge_seen) begin
        slot_count  <= slot_count + 1;
        last_period <= run;
      end
    end
  end

  // undriven pins wander every cycle so a stale value never passes
  always_ff @(posedge pclk) begin
    float_lvl <= (float_lvl === 16'hA5A5) ? 16'h5A5A : 16'hA5A5;
  end

  // wire level seen by the pin input buffers
  always_comb begin
    port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & float_lvl);
  end
endmodule // lcd_panel_model

//--- tb_top.sv
// self-checking bench of the lcd segment/common driver
`timescale 1ns/100ps
module tb_top;
  import lcd_pkg::*;
  typedef struct {logic wr; logic [15:0] idx; logic [31:0] wd; logic [31:0] rd; logic err;} lcd_row_t;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, sub_clk, polarity;
  logic [17:0]           paddr;
  logic [31:0]           pwdata, prdata;
  logic [NUM_SHARED-1:0] port_pin_in, port_pin_out, port_pin_oe;
  logic [NUM_SEG-1:0]    seg_sel;
  logic [NUM_COM-1:0]    com_sel, com_drive;
  int                    slot_count, last_period, fails, compares, sub_cnt;
  lcd_row_t              rows [0:11] = '{
    '{1'b1, IDX_TIMER, 32'h3, 32'h0, 1'b0}, '{1'b0, IDX_TIMER, 32'h0, 32'h3, 1'b0},
    '{1'b1, IDX_MODE, 32'hFF, 32'h0, 1'b0}, '{1'b0, IDX_MODE, 32'h0, 32'hF7, 1'b0},
    '{1'b1, IDX_MODE_CLR, 32'h80, 32'h0, 1'b0}, '{1'b0, IDX_MODE, 32'h0, 32'h77, 1'b0},
    '{1'b1, IDX_MODE_SET, 32'h80, 32'h0, 1'b0}, '{1'b0, IDX_MODE, 32'h0, 32'hF7, 1'b0},
    '{1'b1, IDX_DDM_FIRST, 32'hFF, 32'h0, 1'b0}, '{1'b0, IDX_DDM_FIRST, 32'h0, 32'hF, 1'b0},
    '{1'b0, 16'h1000, 32'h0, 32'h0, 1'b1}, '{1'b1, 16'h1000, 32'h5, 32'h0, 1'b1}};
  logic [2:0]            codes [0:4] = '{MODE_4DIV_B3, MODE_3DIV_B3, MODE_2DIV_B2, MODE_3DIV_B2,
                                         MODE_STATIC};
  logic [3:0]            drv [0:4] = '{4'hF, 4'h7, 4'h3, 4'h7, 4'hF};

  lcd_driver lcd_driver_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_clk(sub_clk), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .seg_sel(seg_sel),
    .com_sel(com_sel), .com_drive(com_drive), .polarity(polarity));
  lcd_panel_model lcd_panel_model_inst (.pclk(pclk), .presetn(presetn), .com_sel(com_sel),
    .polarity(polarity),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .port_pin_in(port_pin_in),
    .slot_count(slot_count), .last_period(last_period));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // free-running subsystem oscillator, six pclk cycles a period
  always @(posedge pclk) begin
    sub_cnt <= (sub_cnt >= 5) ? 0 : sub_cnt + 1;
    sub_clk <= (sub_cnt < 3);
  end

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("CHECK FAILED t=%0t apb answer timed out", $time);
      give_verdict();
    end
  endtask

  // bounded wait for the next common slot, then let outputs settle
  task automatic wait_slot();
    int s, n;
    s = slot_count;
    n = 0;
    while (slot_count == s && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      $display("CHECK FAILED t=%0t slot wait timed out", $time);
      give_verdict();
    end
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic [3:0] mem_val(input int i);
    return i[3:0] ^ 4'h5;
  endfunction

  initial begin
    logic [31:0] rd;
    logic        er, pp;
    logic [39:0] ex;
    int          n, s0;
    {psel, penable, pwrite, paddr, pwdata, sub_clk, sub_cnt} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // register table rows
    foreach (rows[r]) begin
      apb(rows[r].wr, rows[r].idx, rows[r].wd, rd, er);
      chk({39'h0, er}, {39'h0, rows[r].err}, "slverr");
      if (!rows[r].wr) chk({8'h0, rd}, {8'h0, rows[r].rd}, "read data");
    end
    $display("table rows done");
    for (int i = 0; i < 40; i++) apb(1'b1, IDX_DDM_FIRST + 16'(i), {28'h0, mem_val(i)}, rd, er);
    // every display mode, fast clock from subsystem source
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, IDX_MODE, {24'h0, 8'hB0 | {5'h0, codes[m]}}, rd, er);
      wait_slot();
      wait_slot();
      pp = polarity;
      for (int s = 0; s < 5; s++) begin
        wait_slot();
        n = 0;
        for (int k = 0; k < 4; k++) if (com_sel[k] && codes[m] != MODE_STATIC) n = k;
        for (int i = 0; i < 40; i++) ex[i] = |(mem_val(i) & (4'h1 << n));
        chk(seg_sel, ex, "segment codes");
        chk({36'h0, com_drive}, {36'h0, drv[m]}, "commons used");
        chk({36'h0, com_sel}, {36'h0, (codes[m] == MODE_STATIC) ? 4'hF : 4'h1 << n}, "com sel");
        chk({39'h0, polarity}, {39'h0, (codes[m] == MODE_STATIC || n == 0) ? ~pp : pp}, "phase");
        pp = polarity;
      end
    end
    $display("display modes done");
    // every clock rate; one slot is 2^(9-code) ticks of six pclk
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, IDX_MODE, 32'h80 | 32'(c << 4), rd, er);
      repeat (3) wait_slot();
      chk(40'(last_period), 40'(6 * (512 >> c)), "slot period");
    end
    apb(1'b1, IDX_TIMER, 32'h2, rd, er);
    repeat (3) wait_slot();
    chk(40'(last_period), 40'd8192, "main source period");
    $display("clock rates done");
    // supply off freezes slots; software restores it before display use
    apb(1'b1, IDX_TIMER, 32'h1, rd, er);
    repeat (4) @(posedge pclk);
    s0 = slot_count;
    repeat (2000) @(posedge pclk);
    chk(40'(slot_count), 40'(s0), "frozen slots");
    apb(1'b1, IDX_TIMER, 32'h3, rd, er);
    wait_slot();
    // display off and a prohibited code
    apb(1'b1, IDX_MODE, 32'h30, rd, er);
    wait_slot();
    chk(seg_sel, 40'h0, "display off");
    apb(1'b1, IDX_MODE, 32'hB5, rd, er);
    repeat (3) @(posedge pclk);
    chk(seg_sel, 40'h0, "prohibited segments");
    chk({36'h0, com_drive}, 40'h0, "prohibited commons");
    $display("off and prohibited done");
    // shared pins: pairs 0-1, 2-3 and 14-15 as segments, rest outputs high
    apb(1'b1, IDX_MODE, 32'h30, rd, er);
    apb(1'b1, IDX_SEG_CTL, 32'h83, rd, er);
    apb(1'b1, IDX_PORT_DIR, 32'hFFFF, rd, er);
    apb(1'b1, IDX_PORT_OUT, 32'hFFFF, rd, er);
    repeat (6) @(posedge pclk);
    chk({24'h0, port_pin_out}, 40'h3FF0, "pin levels");
    chk({24'h0, port_pin_oe}, 40'hFFFF, "pin drive");
    apb(1'b0, IDX_PORT_IN, 32'h0, rd, er);
    chk({8'h0, rd}, 40'h3FF0, "port read");
    $display("shared pins done");
    // second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(seg_sel, 40'h0, "segments in reset");
    chk({36'h0, com_sel}, 40'h0, "commons in reset");
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({36'h0, com_drive}, 40'hF, "reset mode");
    apb(1'b0, IDX_MODE, 32'h0, rd, er);
    chk({8'h0, rd}, 40'h0, "mode after reset");
    $display("reset done");
    give_verdict();
  end
endmodule // tb_top
